// [eev_core.sv]
/*
  Exception entry and vectoring core with its APB register file.
  Assumes the pipeline presents one-cycle requests synchronous to clk,
  with faultPc already pointing at the branch for a delay-slot fault.
*/
// Functional notes
// - An instruction that raises an exception still counts as executed.
// - Counter overflow raises the perf interrupt only while its enable bit is set.
// - Read-only 32-bit cache fault register loaded on each cache error.
// - Cache fault holds reference type, level, data and tag array flags.
// - Cache fault flags first doubleword, system bus and both-cache errors.
// - Seven flags occupy top bits in fixed order; low 25 bits read zero.
// - Error-type exceptions save the fault PC into fault return PC, no slot flag.
// - Parity-disabled cache errors leave fault return PC unchanged.
// - Return PC bits 40-58: sign extension, or segment-dependent in 64-bit.
// - Exception or fault level forces kernel mode; otherwise privilege field selects mode.
// - General exception sets exception level; trap return clears it unless fault level is set.
// - Reset, soft reset and NMI always go to the fixed reset vector.
// - Soft reset or NMI saves PC and sets boot, restart and fault-level bits.
// - Cache error sets fault level, vectors to base plus 0x100 by boot bit.
// - General exception writes the cause register layout with pending bits kept.
// - Trap return PC is written only when exception level was clear.
// - General vector base depends on the boot vector bit.
// - Offsets: narrow refill 0, wide refill 0x80, cache 0x100, others 0x180.
// - In 32-bit mode the vector is the low half of the 64-bit one.
// - Refill vector choice follows the missed address region, not current mode.
// - Compat supervisor region refills choose by the kernel wide bit.
// - Wide kernel region always wide; low user region chooses by user bit.
// - Translation exceptions load the page pair number into both pointers.
// - Cold reset sets replacement index to upper bound, locked count to 0.
// - Only the highest-priority simultaneous exception is taken.
`timescale 1ns/1ps
`include "eev_consts.svh"

module eev_core #(
  parameter int ENTRIES = 48
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pipeline side
  input  wire eev_pkg::eev_exc_t exc,
  input  wire eev_pkg::eev_cfi_t cfiFlags,
  input  wire logic [63:0]      faultPc,
  input  wire logic [63:0]      missAddr,
  input  wire logic             mode64,
  input  wire logic             parityEn,
  input  wire logic             instrDone,
  input  wire logic [4:0]       extIrq,
  output logic                  pcLoad,
  output logic [63:0]           newPc,
  output logic                  kernelMode,
  output logic [1:0]            privMode,
  output logic                  timerPerfIrq,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr
);
  localparam logic [5:0] RAND_TOP = 6'(ENTRIES - 1);

  logic [31:0] status;
  logic [31:0] cause;
  logic [63:0] trapRetPc;
  logic [63:0] faultRetPc;
  logic [31:0] cfi;
  logic [31:0] ptp;
  logic [31:0] wptp;
  logic [31:0] perfCnt;
  logic [31:0] perfCtl;
  logic [5:0]  random;
  logic [5:0]  wired;

  // Upper address bits as stored in both return PCs
  function automatic logic [63:0] fixHigh(input logic [63:0] pc, input logic m64);
    logic [63:0] f;
    f = pc;
    if (!m64) begin
      f = {{32{pc[31]}}, pc[31:0]};
    end else begin
      f[58:40] = (&pc[63:31]) ? 19'h7ffff : 19'h00000;
    end
    return f;
  endfunction

  // Wide refill choice from the region of the missed address
  function automatic logic wideMiss(input logic [63:0] a, input logic [31:0] sr);
    logic w;
    w = sr[`EEV_SR_KX];
    if (&a[63:32]) begin
      w = sr[`EEV_SR_KX];
    end else if (a[63:62] == 2'b11) begin
      w = 1'b1;
    end else if (a[63:62] == 2'b01) begin
      w = sr[`EEV_SR_SX];
    end else if (a[63:62] == 2'b00) begin
      w = sr[`EEV_SR_UX];
    end
    return w;
  endfunction

  // Priority among simultaneous requests; cold reset is rst itself
  wire anyHi    = exc.softRst | exc.nmi;
  wire takeSoft = anyHi;
  wire takeCerr = exc.cache_fault_info & ~anyHi;
  wire takeGen  = exc.general & ~anyHi & ~exc.cache_fault_info;
  wire anyExc   = anyHi | exc.cache_fault_info | exc.general;
  wire takeEret = exc.return_from_trap_instr & ~anyExc;
  wire exception_level_flag      = status[`EEV_SR_EXL];
  wire fault_level_flag      = status[`EEV_SR_ERL];
  wire boot_vector_select      = status[`EEV_SR_BEV];

  // APB decode
  wire       setup = psel & ~penable;
  wire       accWr = psel & penable & pready & pwrite;
  wire [7:0] idx   = paddr[9:2];
  wire       wrSt  = accWr & (idx == `EEV_IDX_STATUS);
  wire       wrCa  = accWr & (idx == `EEV_IDX_CAUSE);
  wire       wrEL  = accWr & (idx == `EEV_IDX_EPC_LO);
  wire       wrEH  = accWr & (idx == `EEV_IDX_EPC_HI);
  wire       wrFL  = accWr & (idx == `EEV_IDX_FEPC_LO);
  wire       wrFH  = accWr & (idx == `EEV_IDX_FEPC_HI);
  wire       wrPt  = accWr & (idx == `EEV_IDX_PTP);
  wire       wrWp  = accWr & (idx == `EEV_IDX_WPTP);
  wire       wrPc  = accWr & (idx == `EEV_IDX_PCTL);
  wire       wrPn  = accWr & (idx == `EEV_IDX_PCNT);
  wire       wrWi  = accWr & (idx == `EEV_IDX_WIRED);

  // Live cause view: pending bits come from their sources
  wire [31:0] causeRd = {cause[31:16], timerPerfIrq, extIrq, cause[9:0]};
  wire [31:0] genCause = {exc.bd, 1'b0, exc.ce, 12'h000, causeRd[15:8],
                          1'b0, exc.code, 2'b00};

  // Vector selection
  wire        isWide  = wideMiss(missAddr, status);
  wire [63:0] genOff  = (exc.refill & ~exception_level_flag) ?
                        (isWide ? `EEV_OFF_XREF : `EEV_OFF_REF) : `EEV_OFF_OTHER;
  wire [63:0] genBase = boot_vector_select ? `EEV_BASE_BOOT : `EEV_BASE_NORM;
  wire [63:0] cerBase = boot_vector_select ? `EEV_BASE_BOOT : `EEV_BASE_CERR;
  wire [63:0] vec64   = takeSoft ? `EEV_VEC_RESET :
                        takeCerr ? cerBase + `EEV_OFF_CERR : genBase + genOff;
  wire [63:0] target  = takeEret ? (fault_level_flag ? faultRetPc : trapRetPc) : vec64;
  wire [63:0] outPc   = mode64 ? target : {{32{target[31]}}, target[31:0]};

  // Status next value; a hardware event wins over a software write
  logic [31:0] next_status;
  always_comb begin
    next_status = wrSt ? pwdata : status;
    if (takeSoft) begin
      next_status = status | `EEV_SR_SOFT;
    end else if (takeCerr) begin
      next_status = status | (32'h1 << `EEV_SR_ERL);
    end else if (takeGen) begin
      next_status = status | (32'h1 << `EEV_SR_EXL);
    end else if (takeEret) begin
      next_status[`EEV_SR_ERL] = 1'b0;
      next_status[`EEV_SR_EXL] = fault_level_flag ? status[`EEV_SR_EXL] : 1'b0;
    end
  end

  wire [1:0] next_ksu = next_status[`EEV_SR_KSU+1:`EEV_SR_KSU];
  wire       next_lvl = next_status[`EEV_SR_EXL] | next_status[`EEV_SR_ERL];

  // Performance counter; excepting instructions count as executed
  wire        evInstr = instrDone | takeGen | takeCerr;
  wire        cntInc  = (perfCtl[3:0] == 4'h0) | ((perfCtl[3:0] == 4'h1) & evInstr);
  wire        ovf     = cntInc & (&perfCnt) & ~wrPn;
  wire [31:0] ctlWr   = wrPc ? (pwdata & `EEV_PC_MASK) : perfCtl;
  wire [31:0] next_pctl = ctlWr | ({31'h0, ovf} << `EEV_PC_IP); // set wins

  // Read mux
  logic [31:0] rdMux;
  logic        hit;
  always_comb begin
    hit = 1'b1;
    unique case (idx)
      `EEV_IDX_RANDOM:  rdMux = {26'h0, random};
      `EEV_IDX_WIRED:   rdMux = {26'h0, wired};
      `EEV_IDX_PTP:     rdMux = ptp;
      `EEV_IDX_WPTP:    rdMux = wptp;
      `EEV_IDX_STATUS:  rdMux = status;
      `EEV_IDX_CAUSE:   rdMux = causeRd;
      `EEV_IDX_EPC_LO:  rdMux = trapRetPc[31:0];
      `EEV_IDX_EPC_HI:  rdMux = trapRetPc[63:32];
      `EEV_IDX_PCTL:    rdMux = perfCtl;
      `EEV_IDX_PCNT:    rdMux = perfCnt;
      `EEV_IDX_CFI:     rdMux = cfi;
      `EEV_IDX_FEPC_LO: rdMux = faultRetPc[31:0];
      `EEV_IDX_FEPC_HI: rdMux = faultRetPc[63:32];
      default: begin
        rdMux = 32'h0;
        hit   = 1'b0;
      end
    endcase
  end

  // APB handshake: one wait-free access phase per transfer
  always_ff @(posedge clk) begin
    pready  <= ~rst & setup;
    pslverr <= ~rst & setup & (~hit | (paddr[1:0] != 2'b00));
    prdata  <= (~rst & setup) ? rdMux : 32'h0;
  end

  // Status, mode outputs and PC redirect
  always_ff @(posedge clk) begin
    if (rst) begin
      status     <= `EEV_SR_RESET;
      pcLoad     <= 1'b1;
      newPc      <= `EEV_VEC_RESET;
      kernelMode <= 1'b1;
      privMode   <= 2'b00;
    end else begin
      status     <= next_status;
      pcLoad     <= anyExc | takeEret;
      newPc      <= outPc;
      kernelMode <= next_lvl | (next_ksu == 2'b00);
      privMode   <= next_lvl ? 2'b00 : next_ksu;
    end
  end

  // Cause and trap return PC
  always_ff @(posedge clk) begin
    if (rst) begin
      cause     <= 32'h0;
      trapRetPc <= 64'h0;
    end else begin
      if (takeGen) begin
        cause <= genCause;
      end else if (wrCa) begin
        cause[9:8] <= pwdata[9:8];
      end
      if (takeGen & ~exception_level_flag) begin
        trapRetPc <= fixHigh(faultPc, mode64);
      end else if (wrEL) begin
        trapRetPc[31:0] <= pwdata;
      end else if (wrEH) begin
        trapRetPc[63:32] <= pwdata;
      end
    end
  end

  // Fault return PC and cache fault record; cold reset also saves the PC
  always_ff @(posedge clk) begin
    if (rst) begin
      faultRetPc <= fixHigh(faultPc, mode64);
      cfi        <= 32'h0;
    end else begin
      if (takeSoft | (takeCerr & parityEn)) begin
        faultRetPc <= fixHigh(faultPc, mode64);
      end else if (wrFL) begin
        faultRetPc[31:0] <= pwdata;
      end else if (wrFH) begin
        faultRetPc[63:32] <= pwdata;
      end
      if (takeCerr) begin
        cfi <= {cfiFlags, 25'h0};
      end
    end
  end

  // Page table pointers: software owns the base, hardware the page pair
  always_ff @(posedge clk) begin
    if (rst) begin
      ptp  <= 32'h0;
      wptp <= 32'h0;
    end else if (takeGen & exc.tlbExc) begin
      ptp[22:4]  <= missAddr[31:13];
      wptp[30:4] <= missAddr[39:13];
    end else begin
      if (wrPt) begin
        ptp[31:23] <= pwdata[31:23];
      end
      if (wrWp) begin
        wptp[31] <= pwdata[31];
      end
    end
  end

  // Replacement index runs down to the locked count and wraps
  always_ff @(posedge clk) begin
    if (rst) begin
      random <= RAND_TOP;
      wired  <= 6'h00;
    end else if (wrWi) begin
      wired  <= pwdata[5:0];
      random <= RAND_TOP;
    end else begin
      random <= (random == wired) ? RAND_TOP : random - 6'h01;
    end
  end

  // Counter keeps running after overflow; interrupt gated by enable
  always_ff @(posedge clk) begin
    if (rst) begin
      perfCnt      <= 32'h0;
      perfCtl      <= 32'h0;
      timerPerfIrq <= 1'b0;
    end else begin
      perfCnt      <= wrPn ? pwdata : perfCnt + {31'h0, cntInc};
      perfCtl      <= next_pctl;
      timerPerfIrq <= next_pctl[`EEV_PC_IP] & next_pctl[`EEV_PC_IE];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  resetVec_a: assert property (takeSoft |=> pcLoad && newPc == `EEV_VEC_RESET)
    else $error("reset vector not taken");
  softBits_a: assert property (takeSoft |=>
      status == ($past(status) | `EEV_SR_SOFT))
    else $error("soft reset status wrong");
  cfiLoad_a: assert property (takeCerr |=> cfi == {$past(cfiFlags), 25'h0})
    else $error("cache fault info not loaded");
  noParLog_a: assert property (takeCerr && !parityEn && !wrFL && !wrFH
      |=> $stable(faultRetPc))
    else $error("fault PC logged with parity off");
  nestEpc_a: assert property (takeGen && exception_level_flag && !wrEL && !wrEH
      |=> $stable(trapRetPc))
    else $error("nested exception overwrote trap PC");
  genExl_a: assert property (takeGen |=> exception_level_flag && kernelMode && privMode == 2'b00)
    else $error("exception level not set");
  otherOff_a: assert property (takeGen && !exc.refill && mode64 && !boot_vector_select
      |=> newPc == `EEV_BASE_NORM + `EEV_OFF_OTHER)
    else $error("general vector wrong");
  cerrVec_a: assert property (takeCerr && mode64 && boot_vector_select
      |=> fault_level_flag && newPc == `EEV_BASE_BOOT + `EEV_OFF_CERR)
    else $error("cache error vector wrong");
  irqGate_a: assert property (timerPerfIrq |-> perfCtl[`EEV_PC_IE])
    else $error("perf irq while disabled");
  mode32_a: assert property (pcLoad && !$past(mode64) |->
      newPc[63:32] == {32{newPc[31]}})
    else $error("32-bit vector not sign extended");
  randInit_a: assert property ($fell(rst) |-> random == RAND_TOP && wired == 6'h00)
    else $error("replacement index not initialised");
  prio_a: assert property (exc.softRst && exc.cache_fault_info |=> $stable(cfi))
    else $error("lower priority exception taken");
  instrCnt_a: assert property (takeGen && perfCtl[3:0] == 4'h1 && !wrPn
      |=> perfCnt == $past(perfCnt) + 32'h1)
    else $error("excepting instruction not counted");

  softCov_c:   cover property (takeSoft ##1 pcLoad);
  cerrCov_c:   cover property (takeCerr && parityEn);
  nestCov_c:   cover property (takeGen ##[1:20] takeGen && exception_level_flag);
  refillCov_c: cover property (takeGen && exc.refill && !exception_level_flag && isWide);
endmodule

// [eev_consts.svh]
/*
  Constants of the exception entry block: register indices, status bit
  positions, vector bases and offsets.
  Assumes inclusion by bare name from the core module and the bench.
*/
`ifndef EEV_CONSTS_SVH
`define EEV_CONSTS_SVH

// Register indices; byte address is four times the index
`define EEV_IDX_RANDOM   8'h01
`define EEV_IDX_PTP      8'h04
`define EEV_IDX_WIRED    8'h06
`define EEV_IDX_STATUS   8'h0c
`define EEV_IDX_CAUSE    8'h0d
`define EEV_IDX_EPC_LO   8'h0e
`define EEV_IDX_EPC_HI   8'h0f
`define EEV_IDX_WPTP     8'h14
`define EEV_IDX_PCTL     8'h18
`define EEV_IDX_PCNT     8'h19
`define EEV_IDX_CFI      8'h1b
`define EEV_IDX_FEPC_LO  8'h1e
`define EEV_IDX_FEPC_HI  8'h1f

// Status bit positions
`define EEV_SR_EXL   1
`define EEV_SR_ERL   2
`define EEV_SR_KSU   3
`define EEV_SR_UX    5
`define EEV_SR_SX    6
`define EEV_SR_KX    7
`define EEV_SR_SRF   20
`define EEV_SR_BEV   22
`define EEV_SR_RESET 32'h00400004
`define EEV_SR_SOFT  32'h00500004

// Perf control bits
`define EEV_PC_IE    4
`define EEV_PC_IP    5
`define EEV_PC_MASK  32'h0000003f

// Vectors
`define EEV_VEC_RESET 64'hffffffffbfc00000
`define EEV_BASE_BOOT 64'hffffffffbfc00200
`define EEV_BASE_NORM 64'hffffffff80000000
`define EEV_BASE_CERR 64'hffffffffa0000000
`define EEV_OFF_REF   64'h0000000000000000
`define EEV_OFF_XREF  64'h0000000000000080
`define EEV_OFF_CERR  64'h0000000000000100
`define EEV_OFF_OTHER 64'h0000000000000180

`endif

// [eev_pkg.sv]
/*
  Types of the exception entry block.
  Assumes eev_consts.svh is on the include path.
*/
package eev_pkg;
  // One exception request bundle from the pipeline, sampled each cycle
  typedef struct packed {
    logic       softRst;
    logic       nmi;
    logic       cache_fault_info;
    logic       general;
    logic       return_from_trap_instr;
    logic       refill;
    logic       tlbExc;
    logic       bd;
    logic [1:0] ce;
    logic [4:0] code;
  } eev_exc_t;

  // Cache fault flags, top bit first
  typedef struct packed {
    logic isData;
    logic level;
    logic dataArr;
    logic tagArr;
    logic firstDw;
    logic sysBus;
    logic both;
  } eev_cfi_t;
endpackage

// [eev_pipe_model.sv]
/*
  Pipeline-side model: turns a bench request into a one-cycle exception
  pulse and retires an instruction every other cycle.
  Assumes go is raised by the bench for a single clock only.
*/
`timescale 1ns/1ps
module eev_pipe_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Bench side
  input  wire logic              go,
  input  wire eev_pkg::eev_exc_t req,
  input  wire logic [63:0]       reqPc,
  input  wire logic [63:0]       reqMiss,
  // Core side
  output eev_pkg::eev_exc_t      exc,
  output logic [63:0]            faultPc,
  output logic [63:0]            missAddr,
  output logic                   instrDone
);
  // Request stands one cycle only; held longer the core would take it twice
  assign exc      = go ? req : '0;
  assign faultPc  = reqPc;
  assign missAddr = reqMiss;

  // Half-rate retirement keeps the instruction event visibly slower than cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      instrDone <= 1'b0;
    end else begin
      instrDone <= ~instrDone;
    end
  end
endmodule

// [exception_entry_vectoring_tb.sv]
/*
  Self-checking bench of the exception entry core: APB register access,
  exception pulses through the pipeline model, vector and register checks.
  Assumes eev_pkg, eev_consts.svh and eev_pipe_model are compiled first.
*/
`timescale 1ns/1ps
`include "eev_consts.svh"
module exception_entry_vectoring_tb;
  localparam int ENT = 48;
  logic              clk, rst, go, mode64, parityEn, psel, penable, pwrite;
  eev_pkg::eev_exc_t req, exc;
  eev_pkg::eev_cfi_t cfiFlags;
  logic [63:0]       reqPc, reqMiss, faultPc, missAddr, newPc;
  logic [4:0]        extIrq;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              instrDone, pcLoad, kernelMode, timerPerfIrq, pready, pslverr, err;
  logic [1:0]        privMode;
  logic [15:0]       lfsr;
  int                nMismatch, samplesChecked;

  eev_pipe_model i_pipe (.clk(clk), .rst(rst), .go(go), .req(req), .reqPc(reqPc),
    .reqMiss(reqMiss), .exc(exc), .faultPc(faultPc), .missAddr(missAddr),
    .instrDone(instrDone));

  eev_core #(.ENTRIES(ENT)) i_dut (.clk(clk), .rst(rst), .exc(exc), .cfiFlags(cfiFlags),
    .faultPc(faultPc), .missAddr(missAddr), .mode64(mode64), .parityEn(parityEn),
    .instrDone(instrDone), .extIrq(extIrq), .pcLoad(pcLoad), .newPc(newPc),
    .kernelMode(kernelMode), .privMode(privMode), .timerPerfIrq(timerPerfIrq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Expected vector: base chosen by the boot bit plus the offset
  function automatic logic [63:0] vec(input logic boot_vector_select, input logic [11:0] off);
    return (boot_vector_select ? `EEV_BASE_BOOT : `EEV_BASE_NORM) + {52'h0, off};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle limit of its own: only the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk({32'h0, rd}, {32'h0, exp});
  endtask

  task automatic rd64(input logic [7:0] idx, output logic [63:0] v);
    apb(1'b0, idx, 32'h0);
    v[31:0] = rd;
    apb(1'b0, idx + 8'h01, 32'h0);
    v[63:32] = rd;
  endtask

  // Exception pulse; returns mid-cycle after the edge that takes it
  task automatic fire(input eev_pkg::eev_exc_t e, input logic [63:0] pc,
                      input logic [63:0] ma);
    @(posedge clk);
    req     <= e;
    reqPc   <= pc;
    reqMiss <= ma;
    go      <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
  endtask

  task automatic conclude();
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    conclude();
  end

  // Main sequence
  initial begin
    eev_pkg::eev_exc_t e;
    logic [63:0] pc, v, trap_return_pc;
    logic [31:0] st;
    logic [15:0] r;
    logic [63:0] ma [6] = '{64'h0000000010002000, 64'h0000000010002000,
      64'hc000000000004000, 64'hffffffffc0006000, 64'hffffffffc0006000,
      64'hffffffffe0008000};
    logic [7:0]  sb [6] = '{8'h00, 8'h20, 8'h00, 8'h40, 8'h80, 8'h90};
    logic [11:0] offs [6] = '{12'h000, 12'h080, 12'h080, 12'h000, 12'h080, 12'h080};
    lfsr = 16'h0030;
    {go, psel, penable, pwrite} = 4'h0;
    {mode64, parityEn} = 2'h3;
    req = '0;
    cfiFlags = '0;
    {reqPc, reqMiss} = 128'h0;
    extIrq = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    nMismatch = 0;
    samplesChecked = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(newPc, `EEV_VEC_RESET);
    // Index steps down every cycle: one step has passed by the first setup edge
    rdChk(`EEV_IDX_RANDOM, ENT - 2);
    rdChk(`EEV_IDX_STATUS, `EEV_SR_RESET);
    rdChk(`EEV_IDX_WIRED, 32'h0);
    apb(1'b1, `EEV_IDX_CFI, 32'hffffffff);
    rdChk(`EEV_IDX_CFI, 32'h0);
    apb(1'b1, 8'h02, 32'h0);
    chk(err, 1'b1);
    // Cache errors: normal base, boot base with parity off, then 32-bit mode
    for (int i = 0; i < 3; i++) begin
      st = (i == 1) ? 32'h004000e0 : 32'h000000e0;
      apb(1'b1, `EEV_IDX_STATUS, st);
      rd64(`EEV_IDX_FEPC_LO, trap_return_pc);
      mode64   <= (i != 2);
      parityEn <= (i != 1);
      r = rnd();
      cfiFlags <= r[6:0];
      pc = {(i == 2) ? 32'h0 : 32'hffffffff, 1'b1, r[12:0], rnd(), 2'h0};
      e = '0;
      e.cache_fault_info = 1'b1;
      fire(e, pc, 64'h0);
      chk(pcLoad, 1'b1);
      chk(newPc, ((i == 1) ? `EEV_BASE_BOOT : `EEV_BASE_CERR) + `EEV_OFF_CERR);
      rdChk(`EEV_IDX_CFI, {r[6:0], 25'h0});
      rdChk(`EEV_IDX_STATUS, st | 32'h4);
      rd64(`EEV_IDX_FEPC_LO, v);
      chk(v, (i == 1) ? trap_return_pc : {32'hffffffff, pc[31:0]});
    end
    mode64   <= 1'b1;
    parityEn <= 1'b1;
    // Soft reset, NMI, then soft reset racing lower-priority requests
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `EEV_IDX_STATUS, 32'h000000f0);
      r = rnd();
      pc = {32'hffffffff, 1'b1, r[12:0], rnd(), 2'h0};
      e = '0;
      e.softRst = (i != 1);
      e.nmi = (i == 1);
      e.general = (i == 2);
      e.cache_fault_info = (i == 2);
      fire(e, pc, 64'h0);
      chk(newPc, `EEV_VEC_RESET);
      rdChk(`EEV_IDX_STATUS, 32'h005000f4);
      rd64(`EEV_IDX_FEPC_LO, v);
      chk(v, pc);
    end
    // General exceptions from user mode, a nested refill, then trap return
    apb(1'b1, `EEV_IDX_CAUSE, 32'h00000200);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      extIrq <= r[4:0];
      st = r[5] ? 32'h004000f0 : 32'h000000f0;
      apb(1'b1, `EEV_IDX_STATUS, st);
      rdChk(`EEV_IDX_STATUS, st);
      chk(kernelMode, 1'b0);
      e = '0;
      e.general = 1'b1;
      e.bd = r[6];
      e.ce = r[8:7];
      e.code = r[13:9];
      pc = {32'hffffffff, 1'b1, r[12:0], rnd(), 2'h0};
      fire(e, pc, 64'h0);
      chk(newPc, vec(r[5], 12'h180));
      rdChk(`EEV_IDX_CAUSE, {e.bd, 1'b0, e.ce, 12'h0, 1'b0, r[4:0], 2'h2,
                             1'b0, e.code, 2'h0});
      rdChk(`EEV_IDX_STATUS, st | 32'h2);
      chk(kernelMode, 1'b1);
      e.refill = 1'b1;
      fire(e, ~pc, 64'h0);
      chk(newPc, vec(r[5], 12'h180));
      rd64(`EEV_IDX_EPC_LO, v);
      chk(v, pc);
      e = '0;
      e.return_from_trap_instr = 1'b1;
      fire(e, ~pc, 64'h0);
      chk(newPc, pc);
      rdChk(`EEV_IDX_STATUS, st);
      chk(privMode, 2'h2);
    end
    // Refill vector by missed region and its wide bit
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `EEV_IDX_STATUS, {24'h0, sb[i]});
      e = '0;
      e.general = 1'b1;
      e.refill = 1'b1;
      e.tlbExc = 1'b1;
      e.code = 5'h02;
      fire(e, 64'hffffffff80001000, ma[i]);
      chk(newPc, vec(1'b0, offs[i]));
      rdChk(`EEV_IDX_PTP, {9'h0, ma[i][31:13], 4'h0});
      rdChk(`EEV_IDX_WPTP, {1'b0, ma[i][39:13], 4'h0});
    end
    // Counter overflow with the enable off, then on
    apb(1'b1, `EEV_IDX_PCTL, 32'h00000001);
    // An excepting instruction while instructions are counted
    e = '0;
    e.general = 1'b1;
    fire(e, 64'hffffffff80002000, 64'h0);
    chk(newPc, vec(1'b0, 12'h180));
    apb(1'b1, `EEV_IDX_PCNT, 32'hfffffff8);
    repeat (40) @(posedge clk);
    chk(timerPerfIrq, 1'b0);
    rdChk(`EEV_IDX_PCTL, 32'h00000021);
    apb(1'b1, `EEV_IDX_PCTL, 32'h00000031);
    rdChk(`EEV_IDX_PCTL, 32'h00000031);
    chk(timerPerfIrq, 1'b1);
    conclude();
  end
endmodule
